//--- common/ipdc_regs.svh
`ifndef IPDC_REGS_SVH
`define IPDC_REGS_SVH

// Register addresses on the external data bus.
`define IPDC_SEL_ADDR        16'hff62
`define IPDC_POR_ADDR        16'hff63
`define IPDC_MISC_ADDR       16'hfe81
// Select register fields.
`define IPDC_SEL_BUS_CLK     0
`define IPDC_SEL_FABRIC_CLK  1
`define IPDC_SEL_GLOBAL_BUFFER_NOTIFY_BIT        2
`define IPDC_SEL_RING_OSC    3
`define IPDC_SEL_CRYSTAL     4
`define IPDC_SEL_PINS        5
`define IPDC_SEL_WMASK       8'h3f
`define IPDC_SEL_RESET       8'h00
// Guard register and clock select fields.
`define IPDC_POR_DIS_BIT     0
`define IPDC_POR_RESET       8'h00
`define IPDC_MISC_SEL_BIT    0
`define IPDC_MISC_RESET      8'h00
// Power control bits.
`define IPDC_IDLE_BIT        0
`define IPDC_PD_BIT          1
`define IPDC_PROCESSOR_POWER_CONTROL_RESET      8'h30
// Watchdog reset follows time-out by this many clock periods.
`define IPDC_WDOG_GRACE      10'd512
`define IPDC_PC_RESET        16'h0000

`endif

//--- common/ipdc_pkg.sv
package ipdc_pkg;
  typedef enum logic [1:0] {
    IPDC_RUN,
    IPDC_IDLE,
    IPDC_PDOWN
  } ipdc_mode_t;
endpackage

//--- hdl/ipdc_clock_gate.sv
`timescale 1ns/1ps
`include "ipdc_regs.svh"

// Latch-free glitchless gate: enable changes only while clk_in is low.
module ipdc_clock_gate (
  input  wire logic clk_in,
  input  wire logic en,
  input  wire logic hold_high,
  output logic      clk_out
);
  logic en_reg;

  always_ff @(negedge clk_in) begin
    en_reg <= en;
  end

  assign clk_out = hold_high ? 1'b1 : (clk_in & en_reg);
endmodule // ipdc_clock_gate

//--- hdl/ipdc_power_ctrl.sv
`timescale 1ns/1ps
`include "ipdc_regs.svh"

// How it works
// - Writing the idle bit of the power control register enters idle.
// - Idle stops only the processor clock; peripherals keep their clock.
// - Idle freezes processor state; other registers keep their contents.
// - An enabled interrupt clears idle; service runs, then next instruction.
// - Any reset source ends idle.
// - Reset from idle restarts at address zero, without the next instruction.
// - Watchdog time-out in idle wakes; reset follows 512 clocks later.
// - Writing the power-down bit enters power-down.
// - Select bit 0 blocks the bus clock during power-down.
// - Select bit 1 blocks the fabric bus clock during power-down.
// - Select bit 2 signals power-down to every global buffer.
// - Select bit 3 shuts off the ring oscillator during power-down.
// - Select bit 4 blocks the crystal and holds the bus clock high.
// - Select bit 5 signals power-down to every programmable pin.
// - Guard bit 0 disables power-on reset circuitry during power-down.
// - Selected gating acts as soon as power-down is entered.
// - After crystal shutdown, waking selects the ring oscillator.
// - Clock select bit 0: clear picks ring oscillator, set picks crystal.
// - Level external interrupt, enabled globally, restarts clock; exits on release.
// - A wake interrupt clears the power-down bit, re-enabling blocked circuits.
module ipdc_power_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        processor_power_control_wr,
  input  wire logic [7:0]  processor_power_control_wdata,
  output logic      [7:0]  processor_power_control,
  input  wire logic        irq_pending,
  input  wire logic        wake_interrupt_a,
  input  wire logic        wake_interrupt_b,
  input  wire logic        wake_a_enabled,
  input  wire logic        wake_b_enabled,
  input  wire logic        wake_a_level,
  input  wire logic        wake_b_level,
  input  wire logic        global_irq_enable,
  input  wire logic        ext_reset_n,
  input  wire logic        por_event,
  input  wire logic        application_reset_sideband,
  input  wire logic        wdog_timeout,
  input  wire logic        wdog_enabled,
  input  wire logic        wdog_reset_enabled,
  input  wire logic        wdog_restart,
  output logic             wdog_irq,
  output logic             mcu_reset,
  output logic             cpu_clk,
  output logic             cpu_hold,
  output logic             bus_clk,
  output logic             fabric_bus_clk,
  output logic             global_buffer_pd,
  output logic             programmable_pin_pd,
  output logic             ring_osc_off,
  output logic             crystal_off,
  output logic             por_disable,
  output logic             clk_source_crystal,
  output logic             pc_force_zero,
  output logic             powered_down
);
  ipdc_pkg::ipdc_mode_t mode_reg;
  logic [7:0]  sel_reg;
  logic [7:0]  por_reg;
  logic [7:0]  misc_reg;
  logic        crystal_gate_bit_was_off_reg;
  logic        wdog_arm_reg;
  logic [9:0]  wdog_cnt_reg;
  logic        wdog_rst_reg;
  logic        wake_hold_reg;
  logic        any_reset;
  logic        pd_wake;
  logic        in_pd;

  function automatic logic sel_active(input logic [7:0] sel,
                                      input int bit_idx,
                                      input logic pd);
    sel_active = pd & sel[bit_idx];
  endfunction

  // Level-sensitive, enabled external interrupts are the only power-down wake.
  assign pd_wake = global_irq_enable &
                   ((wake_interrupt_a & wake_a_enabled & wake_a_level) |
                    (wake_interrupt_b & wake_b_enabled & wake_b_level));
  assign any_reset = ~ext_reset_n | por_event | application_reset_sideband
                   | wdog_rst_reg;
  assign in_pd = (mode_reg == ipdc_pkg::IPDC_PDOWN);

  // Mode tracking. Power-down stays while the wake level is held; release exits.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= ipdc_pkg::IPDC_RUN;
    end else if (any_reset) begin
      mode_reg <= ipdc_pkg::IPDC_RUN;
    end else begin
      case (mode_reg)
        ipdc_pkg::IPDC_RUN: begin
          if (processor_power_control_wr && processor_power_control_wdata[`IPDC_PD_BIT]) begin
            mode_reg <= ipdc_pkg::IPDC_PDOWN;
          end else if (processor_power_control_wr && processor_power_control_wdata[`IPDC_IDLE_BIT]) begin
            mode_reg <= ipdc_pkg::IPDC_IDLE;
          end
        end
        ipdc_pkg::IPDC_IDLE: begin
          if (irq_pending || wdog_irq) begin
            mode_reg <= ipdc_pkg::IPDC_RUN;
          end
        end
        ipdc_pkg::IPDC_PDOWN: begin
          if (pd_wake) begin
            mode_reg <= ipdc_pkg::IPDC_PDOWN;
          end else if (wake_hold_reg) begin
            mode_reg <= ipdc_pkg::IPDC_RUN;
          end
        end
        default: mode_reg <= ipdc_pkg::IPDC_RUN;
      endcase
    end
  end

  // Remembers that a wake level was seen so its release ends power-down.
  always_ff @(posedge clk) begin
    if (rst || !in_pd) begin
      wake_hold_reg <= 1'b0;
    end else if (pd_wake) begin
      wake_hold_reg <= 1'b1;
    end
  end

  // Power control register view: mode bits clear themselves on wake.
  always_comb begin
    processor_power_control = `IPDC_PROCESSOR_POWER_CONTROL_RESET;
    processor_power_control[`IPDC_IDLE_BIT] =
      (mode_reg == ipdc_pkg::IPDC_IDLE);
    processor_power_control[`IPDC_PD_BIT] = in_pd & ~pd_wake;
  end

  // Register writes; select bits 7 and 6 are never stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_reg  <= `IPDC_SEL_RESET;
      por_reg  <= `IPDC_POR_RESET;
    end else if (bus_wr && bus_addr == `IPDC_SEL_ADDR) begin
      sel_reg <= bus_wdata & `IPDC_SEL_WMASK;
    end else if (bus_wr && bus_addr == `IPDC_POR_ADDR) begin
      por_reg <= bus_wdata & 8'h01;
    end
  end

  // Clock select survives non-power reset sources except in crystal-off power-down; wake or reset there forces ring.
  always_ff @(posedge clk) begin
    if (rst) begin
      misc_reg <= `IPDC_MISC_RESET;
    end else if (in_pd && sel_reg[`IPDC_SEL_CRYSTAL] && !pd_wake
                 && wake_hold_reg) begin
      misc_reg[`IPDC_MISC_SEL_BIT] <= 1'b0;
    end else if (in_pd && sel_reg[`IPDC_SEL_CRYSTAL] && any_reset) begin
      misc_reg[`IPDC_MISC_SEL_BIT] <= 1'b0;
    end else if (bus_wr && bus_addr == `IPDC_MISC_ADDR) begin
      misc_reg <= bus_wdata & 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crystal_gate_bit_was_off_reg <= 1'b0;
    end else begin
      crystal_gate_bit_was_off_reg <= sel_active(sel_reg, `IPDC_SEL_CRYSTAL, in_pd);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        `IPDC_SEL_ADDR:  bus_rdata <= sel_reg & `IPDC_SEL_WMASK;
        `IPDC_POR_ADDR:  bus_rdata <= por_reg;
        `IPDC_MISC_ADDR: bus_rdata <= misc_reg;
        default:         bus_rdata <= 8'h00;
      endcase
    end
  end

  // Watchdog grace window: time-out interrupt, then reset unless restarted.
  always_ff @(posedge clk) begin
    if (rst || wdog_restart || !wdog_enabled) begin
      wdog_arm_reg <= 1'b0;
      wdog_cnt_reg <= 10'd0;
      wdog_rst_reg <= 1'b0;
    end else if (wdog_timeout && !wdog_arm_reg) begin
      wdog_arm_reg <= 1'b1;
      wdog_cnt_reg <= 10'd0;
      wdog_rst_reg <= 1'b0;
    end else if (wdog_arm_reg) begin
      if (wdog_cnt_reg == `IPDC_WDOG_GRACE - 10'd1) begin
        wdog_arm_reg <= 1'b0;
        wdog_rst_reg <= wdog_reset_enabled;
      end else begin
        wdog_cnt_reg <= wdog_cnt_reg + 10'd1;
        wdog_rst_reg <= 1'b0;
      end
    end else begin
      wdog_rst_reg <= 1'b0;
    end
  end

  assign wdog_irq = wdog_enabled & wdog_timeout;

  // Any reset source restarts the processor at the reset vector at once.
  assign mcu_reset = any_reset;
  assign pc_force_zero = any_reset;

  // Freezing state is done by holding the core; its registers simply keep.
  assign cpu_hold = (mode_reg != ipdc_pkg::IPDC_RUN);
  assign powered_down = in_pd;

  // Peripherals stay on bus clock in idle; only the core clock stops.
  ipdc_clock_gate u_cpu_gate (
    .clk_in    (clk),
    .en        (mode_reg == ipdc_pkg::IPDC_RUN || any_reset),
    .hold_high (1'b0),
    .clk_out   (cpu_clk)
  );

  // Gating is combinational on mode so it acts on entry; the wake level
  // releases it early so the oscillator restarts before exit.
  ipdc_clock_gate u_bus_gate (
    .clk_in    (clk),
    .en        (~(sel_active(sel_reg, `IPDC_SEL_BUS_CLK, in_pd)
                  & ~pd_wake)),
    .hold_high (sel_active(sel_reg, `IPDC_SEL_CRYSTAL, in_pd)
                & ~pd_wake & ~any_reset),
    .clk_out   (bus_clk)
  );

  ipdc_clock_gate u_fabric_gate (
    .clk_in    (clk),
    .en        (~(sel_active(sel_reg, `IPDC_SEL_FABRIC_CLK, in_pd)
                  & ~pd_wake)),
    .hold_high (1'b0),
    .clk_out   (fabric_bus_clk)
  );

  assign global_buffer_pd =
    sel_active(sel_reg, `IPDC_SEL_GLOBAL_BUFFER_NOTIFY_BIT, in_pd);
  assign programmable_pin_pd =
    sel_active(sel_reg, `IPDC_SEL_PINS, in_pd);
  assign ring_osc_off =
    sel_active(sel_reg, `IPDC_SEL_RING_OSC, in_pd) & ~pd_wake;
  // A reset restarts the crystal together with the held bus clock.
  assign crystal_off =
    sel_active(sel_reg, `IPDC_SEL_CRYSTAL, in_pd) & ~pd_wake
    & ~any_reset;
  assign por_disable = in_pd & por_reg[`IPDC_POR_DIS_BIT];
  // Software must retime memory and wait for the crystal around this switch.
  assign clk_source_crystal = misc_reg[`IPDC_MISC_SEL_BIT]
                              & ~crystal_gate_bit_was_off_reg;
endmodule // ipdc_power_ctrl

//--- bench/ipdc_power_ctrl_props.sv
`timescale 1ns/1ps
module ipdc_power_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       processor_power_control_wr,
  input wire logic [7:0] processor_power_control_wdata,
  input wire logic [7:0] processor_power_control,
  input wire logic       powered_down,
  input wire logic       cpu_hold,
  input wire logic       crystal_off,
  input wire logic       bus_clk,
  input wire logic       mcu_reset,
  input wire logic       pc_force_zero,
  input wire logic       ext_reset_n,
  input wire logic       application_reset_sideband,
  input wire logic       wake_interrupt_a,
  input wire logic       wake_a_enabled,
  input wire logic       wake_a_level,
  input wire logic       global_irq_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wake;
    powered_down && wake_interrupt_a && wake_a_enabled && wake_a_level
      && global_irq_enable;
  endsequence
  property p_pd_enter;
    processor_power_control_wr && processor_power_control_wdata[1] && !mcu_reset |=> powered_down;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("Power-down not entered.");
  property p_idle_enter;
    processor_power_control_wr && processor_power_control_wdata[1:0] == 2'h1 && !mcu_reset
      |=> cpu_hold && processor_power_control[0];
  endproperty
  a_idle_enter: assert property (p_idle_enter)
    else $error("Idle not entered.");
  property p_crystal_gate_bit_high;
    crystal_off [*2] |-> bus_clk;
  endproperty
  a_crystal_gate_bit_high: assert property (p_crystal_gate_bit_high)
    else $error("Bus clock not held high.");
  property p_reset_src;
    application_reset_sideband || !ext_reset_n |-> mcu_reset && pc_force_zero;
  endproperty
  a_reset_src: assert property (p_reset_src)
    else $error("Reset source not passed on.");
  property p_reset_exit;
    mcu_reset |=> !powered_down && !cpu_hold;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("Reset did not end the mode.");
  // The wake line may keep the block down for one more edge after release.
  property p_pd_hold;
    powered_down && !wake_interrupt_a && !$past(wake_interrupt_a)
      && !$past(wake_interrupt_a, 2) && !mcu_reset |=> powered_down;
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("Power-down left without cause.");
  property p_wake_bit;
    s_wake |-> ##[0:2] !processor_power_control[1] && !crystal_off;
  endproperty
  a_wake_bit: assert property (p_wake_bit)
    else $error("Wake did not clear the bit.");
  property p_wake_exit;
    s_wake ##1 !wake_interrupt_a |-> ##[0:2] !powered_down;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("Power-down not left on release.");
endmodule // ipdc_power_props

bind ipdc_power_ctrl ipdc_power_props u_props (
  .clk, .rst, .processor_power_control_wr, .processor_power_control_wdata, .processor_power_control,
  .powered_down, .cpu_hold, .crystal_off, .bus_clk, .mcu_reset,
  .pc_force_zero, .ext_reset_n, .application_reset_sideband,
  .wake_interrupt_a, .wake_a_enabled, .wake_a_level, .global_irq_enable
);

//--- bench/ipdc_core_model.sv
`timescale 1ns/1ps
module ipdc_core_model (
  input  wire logic       clk,
  input  wire logic       cpu_hold,
  input  wire logic       req_wr,
  input  wire logic [7:0] req_data,
  input  wire logic       req_wake,
  output logic            processor_power_control_wr = 1'b0,
  output logic      [7:0] processor_power_control_wdata = 8'h00,
  output logic            wake_interrupt_a = 1'b0
);
  logic [3:0] hold_reg = 4'h0;
  // A halted core fetches nothing, so it cannot write while held.
  always_ff @(posedge clk) begin
    processor_power_control_wr <= req_wr & ~cpu_hold;
    processor_power_control_wdata <= req_wr ? req_data : ~req_data;
  end
  // The wake level is kept up long enough for the oscillator to start.
  always_ff @(posedge clk) begin
    hold_reg <= req_wake ? 4'h8 : hold_reg - {3'h0, |hold_reg};
    wake_interrupt_a <= req_wake | (|hold_reg);
  end
endmodule // ipdc_core_model

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "ipdc_regs.svh"
module testbench;
  logic        clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00, req_data = 8'h00, bus_rdata, processor_power_control_wdata;
  logic [7:0]  processor_power_control;
  logic req_wr = 1'b0, req_wake = 1'b0, irq_pending = 1'b0;
  logic wake_a_enabled = 1'b0, global_irq_enable = 1'b0;
  logic ext_reset_n = 1'b1, wdog_timeout = 1'b0;
  logic application_reset_sideband = 1'b0, wdog_restart = 1'b0;
  logic wdog_enabled = 1'b0, wdog_reset_enabled = 1'b0;
  logic processor_power_control_wr, wake_interrupt_a, wdog_irq, cpu_clk;
  logic mcu_reset, cpu_hold, bus_clk, fabric_bus_clk, global_buffer_pd;
  logic programmable_pin_pd, ring_osc_off, crystal_off, por_disable;
  logic clk_source_crystal, pc_force_zero, powered_down;
  int   mismatches = 0, samples_checked = 0, cycles = 0;
  ipdc_core_model u_core (.clk, .cpu_hold, .req_wr, .req_data, .req_wake,
    .processor_power_control_wr, .processor_power_control_wdata, .wake_interrupt_a);
  ipdc_power_ctrl DUT (.clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .processor_power_control_wr, .processor_power_control_wdata, .processor_power_control,
    .irq_pending, .wake_interrupt_a, .wake_interrupt_b(1'b0),
    .wake_a_enabled, .wake_b_enabled(1'b0), .wake_a_level(1'b1),
    .wake_b_level(1'b1), .global_irq_enable, .ext_reset_n, .por_event(1'b0),
    .application_reset_sideband, .wdog_timeout, .wdog_enabled,
    .wdog_reset_enabled, .wdog_restart, .wdog_irq, .mcu_reset, .cpu_clk,
    .cpu_hold, .bus_clk, .fabric_bus_clk, .global_buffer_pd,
    .programmable_pin_pd, .ring_osc_off, .crystal_off, .por_disable,
    .clk_source_crystal, .pc_force_zero, .powered_down);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    tick(1);
    bus_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus_addr = a;
    bus_rd = 1'b1;
    tick(1);
    bus_rd = 1'b0;
    chk(bus_rdata, e);
    tick(1);
  endtask
  task automatic core(input logic [7:0] d);
    req_data = d;
    req_wr = 1'b1;
    tick(1);
    req_wr = 1'b0;
    tick(1);
  endtask
  task automatic t_regs;
    rd(`IPDC_SEL_ADDR, 8'h00);
    rd(`IPDC_POR_ADDR, 8'h00);
    rd(`IPDC_MISC_ADDR, 8'h00);
    rd(16'hff64, 8'h00);
    chk(processor_power_control, 8'h30);
    wr(`IPDC_SEL_ADDR, 8'hff);
    rd(`IPDC_SEL_ADDR, 8'h3f);
    wr(`IPDC_POR_ADDR, 8'hff);
    rd(`IPDC_POR_ADDR, 8'h01);
  endtask
  task automatic t_pdown;
    wr(`IPDC_MISC_ADDR, 8'h01);
    chk(clk_source_crystal, 1'b1);
    wr(`IPDC_SEL_ADDR, 8'h3d);
    core(8'h02);
    chk(powered_down, 1'b1);
    chk({global_buffer_pd, ring_osc_off, crystal_off}, 3'h7);
    chk({programmable_pin_pd, por_disable}, 2'h3);
    tick(1);
    #50;
    chk({bus_clk, fabric_bus_clk}, 2'h2);
    tick(1);
    wake_a_enabled = 1'b1;
    req_wake = 1'b1;
    tick(1);
    req_wake = 1'b0;
    tick(12);
    chk(powered_down, 1'b1);
    global_irq_enable = 1'b1;
    req_wake = 1'b1;
    tick(3);
    chk({processor_power_control[1], crystal_off}, 2'h0);
    req_wake = 1'b0;
    tick(12);
    chk({powered_down, clk_source_crystal}, 2'h0);
    wr(`IPDC_MISC_ADDR, 8'h01);
    chk(clk_source_crystal, 1'b1);
    wr(`IPDC_SEL_ADDR, 8'h03);
    core(8'h02);
    tick(1);
    chk({bus_clk, fabric_bus_clk, crystal_off}, 3'h0);
    ext_reset_n = 1'b0;
    tick(1);
    chk({mcu_reset, pc_force_zero}, 2'h3);
    ext_reset_n = 1'b1;
    tick(1);
    chk(powered_down, 1'b0);
  endtask
  task automatic t_idle;
    chk({cpu_clk, bus_clk}, 2'h3);
    core(8'h01);
    chk({cpu_hold, processor_power_control}, 9'h131);
    tick(1);
    chk({cpu_clk, bus_clk}, 2'h1);
    irq_pending = 1'b1;
    tick(1);
    irq_pending = 1'b0;
    chk({cpu_hold, processor_power_control[0]}, 2'h0);
    core(8'h01);
    wdog_enabled = 1'b1;
    wdog_timeout = 1'b1;
    #1;
    chk(wdog_irq, 1'b1);
    tick(1);
    wdog_timeout = 1'b0;
    chk(cpu_hold, 1'b0);
    core(8'h01);
    application_reset_sideband = 1'b1;
    #1;
    chk({mcu_reset, pc_force_zero}, 2'h3);
    tick(1);
    application_reset_sideband = 1'b0;
    tick(1);
    chk({cpu_hold, processor_power_control}, 9'h030);
  endtask
  task automatic t_wdog;
    int n;
    n = 0;
    wdog_reset_enabled = 1'b1;
    core(8'h01);
    wdog_timeout = 1'b1;
    tick(1);
    wdog_timeout = 1'b0;
    tick(100);
    wdog_restart = 1'b1;
    tick(1);
    wdog_restart = 1'b0;
    repeat (600) begin
      tick(1);
      if (mcu_reset !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
    wdog_timeout = 1'b1;
    tick(1);
    wdog_timeout = 1'b0;
    while (mcu_reset !== 1'b1 && n < 700) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'd512);
    tick(3);
    chk(cpu_hold, 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    rst = 1'b0;
    tick(1);
    t_regs();
    t_pdown();
    t_idle();
    t_wdog();
    finish_test();
  end
endmodule // testbench
